// ==== include/uic_pkg.sv ====
// Package for the channel interrupt and FIFO control block.
// Assumes an 8-bit register view reached over a 32-bit classic Wishbone slave.
package uic_pkg;
   // ----------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------
   localparam logic [7:0] IDX_INT_ENABLE = 8'h01;
   localparam logic [7:0] IDX_INT_IDENT  = 8'h02;
   localparam logic [7:0] IDX_FIFO_CTRL  = 8'h02;
   localparam logic [7:0] IDX_SRC_STATUS = 8'h20;
   localparam logic [7:0] IDX_TRIG_LEVEL = 8'h21;
   localparam int         ADDR_W         = 10;
   localparam logic [ADDR_W-1:0] ADR_INT_ENABLE = ADDR_W'({IDX_INT_ENABLE, 2'b00});
   localparam logic [ADDR_W-1:0] ADR_INT_IDENT  = ADDR_W'({IDX_INT_IDENT, 2'b00});
   localparam logic [ADDR_W-1:0] ADR_SRC_STATUS = ADDR_W'({IDX_SRC_STATUS, 2'b00});
   localparam logic [ADDR_W-1:0] ADR_TRIG_LEVEL = ADDR_W'({IDX_TRIG_LEVEL, 2'b00});

   // ----------------------------------------
   // Enable bit positions
   // ----------------------------------------
   localparam int IE_RX_DATA  = 0;
   localparam int IE_TX_EMPTY = 1;
   localparam int IE_RX_ERR   = 2;
   localparam int IE_MODEM    = 3;
   localparam int IE_XOFF     = 4;
   localparam int IE_RTS      = 5;
   localparam int IE_CTS      = 6;
   localparam logic [7:0] INT_ENABLE_RST = 8'h00;

   // ----------------------------------------
   // Identification codes
   // ----------------------------------------
   localparam logic [7:0] ID_NONE    = 8'hC1;
   localparam logic [7:0] ID_RX_ERR  = 8'hC6;
   localparam logic [7:0] ID_RX_DATA = 8'hC4;
   localparam logic [7:0] ID_RX_TOUT = 8'hCC;
   localparam logic [7:0] ID_TX_EMPT = 8'hC2;
   localparam logic [7:0] ID_MODEM   = 8'hC0;
   localparam logic [7:0] ID_XOFF    = 8'hD0;
   localparam logic [7:0] ID_FLOWCHG = 8'hE0;

   // ----------------------------------------
   // FIFO control fields
   // ----------------------------------------
   localparam int FC_ENABLE   = 0;
   localparam int FC_RX_FLUSH = 1;
   localparam int FC_TX_FLUSH = 2;
   localparam int FC_TX_LSB   = 4;
   localparam int FC_RX_LSB   = 6;
   localparam logic [7:0] FIFO_CTRL_RST = 8'h00;

   // Trigger tables, index is the two-bit code
   localparam logic [6:0] RX_TRIG_STD0 = 7'h01;
   localparam logic [6:0] RX_TRIG_STD1 = 7'h04;
   localparam logic [6:0] RX_TRIG_STD2 = 7'h08;
   localparam logic [6:0] RX_TRIG_STD3 = 7'h0E;
   localparam logic [6:0] RX_TRIG_ENH0 = 7'h0F;
   localparam logic [6:0] RX_TRIG_ENH1 = 7'h1F;
   localparam logic [6:0] RX_TRIG_ENH2 = 7'h3F;
   localparam logic [6:0] RX_TRIG_ENH3 = 7'h6F;
   localparam logic [6:0] TX_TRIG_ENH0 = 7'h10;
   localparam logic [6:0] TX_TRIG_ENH1 = 7'h20;
   localparam logic [6:0] TX_TRIG_ENH2 = 7'h40;
   localparam logic [6:0] TX_TRIG_ENH3 = 7'h70;

   typedef enum logic [2:0] {
      FL_IDLE = 3'b001,
      FL_BUSY = 3'b010,
      FL_DONE = 3'b100
   } uic_flush_t;
endpackage

// ==== hdl/uic_flush_ctl.sv ====
// Self-clearing flush strobe: one instance per FIFO.
// Assumes the FIFO raises done_i one or more cycles after req_o.
`timescale 1ns/1ps
module uic_flush_ctl (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   input  wire logic start_i,
   input  wire logic done_i,
   output logic      req_o,
   output logic      pend_o
);
   uic_pkg::uic_flush_t st_q;
   uic_pkg::uic_flush_t st_d;

   // Start while busy folds into the running flush
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         uic_pkg::FL_IDLE: if (start_i) st_d = uic_pkg::FL_BUSY;
         uic_pkg::FL_BUSY: if (done_i) st_d = uic_pkg::FL_DONE;
         // A start in the closing cycle opens a fresh flush instead of being lost
         uic_pkg::FL_DONE: st_d = start_i ? uic_pkg::FL_BUSY : uic_pkg::FL_IDLE;
         default:          st_d = uic_pkg::FL_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= uic_pkg::FL_IDLE;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end

   assign req_o  = (st_q == uic_pkg::FL_BUSY);
   assign pend_o = (st_q != uic_pkg::FL_IDLE);

   a_flush_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && req_o && done_i) |=> !req_o)
      else $error("flush strobe did not clear after done");
endmodule

// ==== hdl/uic_irq_fifo_ctl.sv ====
// Interrupt enable, identification and FIFO control of one serial channel.
// Assumes source levels and flush-done come from channel logic on clk_i.
`timescale 1ns/1ps
module uic_irq_fifo_ctl (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // Channel side
   input  wire logic        enhanced_i,
   input  wire logic        src_rx_err_i,
   input  wire logic        src_rx_data_i,
   input  wire logic        src_rx_tout_i,
   input  wire logic        src_tx_empty_i,
   input  wire logic        src_modem_i,
   input  wire logic        src_xoff_i,
   input  wire logic        src_rts_chg_i,
   input  wire logic        src_cts_chg_i,
   input  wire logic        rx_flush_done_i,
   input  wire logic        tx_flush_done_i,
   output logic             irq_o,
   output logic             fifo_en_o,
   output logic             rx_flush_o,
   output logic             tx_flush_o,
   output logic [6:0]       rx_trig_o,
   output logic [6:0]       tx_trig_o
);
   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic [7:0]  int_enable_q;
   logic [7:0]  fifo_ctrl_q;
   logic [7:0]  int_ident_q;
   logic        ack_q;
   logic        err_q;
   logic [31:0] rdat_q;

   wire req_w      = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
   wire lane0_w    = wb_sel_i[0];
   wire hit_ie_w   = (wb_adr_i == uic_pkg::ADR_INT_ENABLE);
   wire hit_id_w   = (wb_adr_i == uic_pkg::ADR_INT_IDENT);
   wire hit_st_w   = (wb_adr_i == uic_pkg::ADR_SRC_STATUS);
   wire hit_tl_w   = (wb_adr_i == uic_pkg::ADR_TRIG_LEVEL);
   wire mapped_w   = hit_ie_w || hit_id_w || hit_st_w || hit_tl_w;
   wire wr_ie_w    = req_w && wb_we_i && lane0_w && hit_ie_w;
   wire wr_fc_w    = req_w && wb_we_i && lane0_w && hit_id_w;

   // ----------------------------------------
   // Source gating and priority
   // ----------------------------------------
   // receive error gate
   wire pend_err_w  = src_rx_err_i && int_enable_q[uic_pkg::IE_RX_ERR];
   wire pend_data_w = src_rx_data_i && int_enable_q[uic_pkg::IE_RX_DATA];
   // Timeout shares the receive data enable, as on classic parts
   wire pend_tout_w = src_rx_tout_i && int_enable_q[uic_pkg::IE_RX_DATA];
   wire pend_tx_w   = src_tx_empty_i && int_enable_q[uic_pkg::IE_TX_EMPTY];
   wire pend_mdm_w  = src_modem_i && int_enable_q[uic_pkg::IE_MODEM];
   wire pend_xoff_w = src_xoff_i && int_enable_q[uic_pkg::IE_XOFF];
   wire pend_flow_w = (src_rts_chg_i && int_enable_q[uic_pkg::IE_RTS])
                   || (src_cts_chg_i && int_enable_q[uic_pkg::IE_CTS]);
   wire any_pend_w  = pend_err_w || pend_data_w || pend_tout_w || pend_tx_w
                   || pend_mdm_w || pend_xoff_w || pend_flow_w;

   wire [7:0] ident_d =
        pend_err_w  ? uic_pkg::ID_RX_ERR  :
        pend_data_w ? uic_pkg::ID_RX_DATA :
        pend_tout_w ? uic_pkg::ID_RX_TOUT :
        pend_tx_w   ? uic_pkg::ID_TX_EMPT :
        pend_mdm_w  ? uic_pkg::ID_MODEM   :
        pend_xoff_w ? uic_pkg::ID_XOFF    :
        pend_flow_w ? uic_pkg::ID_FLOWCHG : uic_pkg::ID_NONE;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // identification reset value
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         int_ident_q <= uic_pkg::ID_NONE;
      end else if (ce_i) begin
         int_ident_q <= ident_d;
      end
   end

   // all eight bits stored, bit 7 plain
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         int_enable_q <= uic_pkg::INT_ENABLE_RST;
      end else if (ce_i && wr_ie_w) begin
         int_enable_q <= wb_dat_i[7:0];
      end
   end

   // write-only control, flush bits held at zero here
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fifo_ctrl_q <= uic_pkg::FIFO_CTRL_RST;
      end else if (ce_i && wr_fc_w) begin
         fifo_ctrl_q <= {wb_dat_i[7:4], 1'b0, 2'b00, wb_dat_i[uic_pkg::FC_ENABLE]};
      end
   end

   // ----------------------------------------
   // Flush strobes
   // ----------------------------------------
   logic rx_pend_w;
   logic tx_pend_w;

   uic_flush_ctl u_rx_flush (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .start_i   (wr_fc_w && wb_dat_i[uic_pkg::FC_RX_FLUSH]),
      .done_i    (rx_flush_done_i),
      .req_o     (rx_flush_o),
      .pend_o    (rx_pend_w)
   );

   uic_flush_ctl u_tx_flush (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .start_i   (wr_fc_w && wb_dat_i[uic_pkg::FC_TX_FLUSH]),
      .done_i    (tx_flush_done_i),
      .req_o     (tx_flush_o),
      .pend_o    (tx_pend_w)
   );

   // ----------------------------------------
   // Trigger levels
   // ----------------------------------------
   wire [1:0] rx_code_w = fifo_ctrl_q[uic_pkg::FC_RX_LSB +: 2];
   wire [1:0] tx_code_w = fifo_ctrl_q[uic_pkg::FC_TX_LSB +: 2];
   wire [6:0] rx_std_w = (rx_code_w == 2'h0) ? uic_pkg::RX_TRIG_STD0 :
                         (rx_code_w == 2'h1) ? uic_pkg::RX_TRIG_STD1 :
                         (rx_code_w == 2'h2) ? uic_pkg::RX_TRIG_STD2 : uic_pkg::RX_TRIG_STD3;
   wire [6:0] rx_enh_w = (rx_code_w == 2'h0) ? uic_pkg::RX_TRIG_ENH0 :
                         (rx_code_w == 2'h1) ? uic_pkg::RX_TRIG_ENH1 :
                         (rx_code_w == 2'h2) ? uic_pkg::RX_TRIG_ENH2 : uic_pkg::RX_TRIG_ENH3;
   // transmit table; code 01b taken as 32
   wire [6:0] tx_enh_w = (tx_code_w == 2'h0) ? uic_pkg::TX_TRIG_ENH0 :
                         (tx_code_w == 2'h1) ? uic_pkg::TX_TRIG_ENH1 :
                         (tx_code_w == 2'h2) ? uic_pkg::TX_TRIG_ENH2 : uic_pkg::TX_TRIG_ENH3;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_trig_o <= uic_pkg::RX_TRIG_STD0;
         tx_trig_o <= uic_pkg::TX_TRIG_ENH0;
         fifo_en_o <= 1'b0;
         irq_o     <= 1'b0;
      end else if (ce_i) begin
         rx_trig_o <= enhanced_i ? rx_enh_w : rx_std_w;
         // Outside enhanced mode the transmit trigger is fixed at the first entry
         tx_trig_o <= enhanced_i ? tx_enh_w : uic_pkg::TX_TRIG_ENH0;
         fifo_en_o <= fifo_ctrl_q[uic_pkg::FC_ENABLE];
         irq_o     <= any_pend_w;
      end
   end

   // ----------------------------------------
   // Read data and answer
   // ----------------------------------------
   wire [7:0] status_w = {rx_pend_w, tx_pend_w, enhanced_i, fifo_ctrl_q[uic_pkg::FC_ENABLE],
                          3'h0, any_pend_w};
   wire [31:0] rd_mux_w = hit_ie_w ? {24'h000000, int_enable_q} :
                          hit_id_w ? {24'h000000, int_ident_q} :
                          hit_st_w ? {24'h000000, status_w} :
                          hit_tl_w ? {18'h00000, tx_trig_o, rx_trig_o} : 32'h00000000;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_q  <= 1'b0;
         err_q  <= 1'b0;
         rdat_q <= 32'h00000000;
      end else if (ce_i) begin
         ack_q  <= req_w && mapped_w;
         err_q  <= req_w && !mapped_w;
         rdat_q <= (req_w && !wb_we_i) ? rd_mux_w : rdat_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign wb_dat_o = rdat_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_ident_bit0: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i |=> (int_ident_q[0] == !$past(any_pend_w)))
      else $error("identification bit 0 disagrees with pending state");
   a_ident_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && !any_pend_w) |=> int_ident_q == uic_pkg::ID_NONE)
      else $error("idle identification code wrong");
   a_err_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && pend_err_w) |=> int_ident_q == uic_pkg::ID_RX_ERR)
      else $error("receive error not reported first");
   a_tout_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && pend_tout_w && !pend_err_w && !pend_data_w) |=> int_ident_q == uic_pkg::ID_RX_TOUT)
      else $error("timeout code wrong");
   a_flow_last: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ($past(ce_i) && int_ident_q == uic_pkg::ID_FLOWCHG) |->
         $past(pend_flow_w && !(pend_err_w || pend_data_w || pend_tout_w || pend_tx_w
                                || pend_mdm_w || pend_xoff_w)))
      else $error("flow change outranked a higher source");
   a_rx_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && !int_enable_q[uic_pkg::IE_RX_DATA]) |=> int_ident_q != uic_pkg::ID_RX_DATA)
      else $error("masked receive data reported");
   a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i |=> irq_o == (int_ident_q != uic_pkg::ID_NONE))
      else $error("interrupt output disagrees with identification");
   a_fifo_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && wr_fc_w) ##1 ce_i |=> fifo_en_o == $past(fifo_ctrl_q[uic_pkg::FC_ENABLE]))
      else $error("FIFO mode output did not follow the write");
   a_rx_flush: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && wr_fc_w && wb_dat_i[uic_pkg::FC_RX_FLUSH] && !rx_pend_w) |=> rx_flush_o)
      else $error("receive flush not started");
   a_rx_trig: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ce_i && enhanced_i && rx_code_w == 2'h3) |=> rx_trig_o == uic_pkg::RX_TRIG_ENH3)
      else $error("enhanced receive trigger wrong");

   c_rx_err:   cover property (@(posedge clk_i) int_ident_q == uic_pkg::ID_RX_ERR);
   c_flow:     cover property (@(posedge clk_i) int_ident_q == uic_pkg::ID_FLOWCHG);
   c_tx_flush: cover property (@(posedge clk_i) tx_flush_o ##1 !tx_flush_o);
   c_unmapped: cover property (@(posedge clk_i) wb_err_o);
endmodule

// ==== verification/uic_fifo_model.sv ====
// Stand-in for the channel FIFOs on the far side of the flush strobes.
// Assumes each request is a level that stays high until done is seen.
`timescale 1ns/1ps
module uic_fifo_model (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [3:0] delay_i,
   input  wire logic [1:0] req_i,
   output logic      [1:0] done_o
);
   logic [3:0] cnt_q [2];

   // ----------------------------------------
   // Flush responder, bit 0 receive, bit 1 transmit
   // ----------------------------------------
   // Slow answers show whether the strobe waits for done
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q  <= '{4'h0, 4'h0};
         done_o <= 2'b00;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (!req_i[k]) begin
               cnt_q[k]  <= 4'h0;
               done_o[k] <= 1'b0;
            end else if (cnt_q[k] >= delay_i) begin
               done_o[k] <= 1'b1;
            end else begin
               cnt_q[k] <= cnt_q[k] + 4'h1;
            end
         end
      end
   end
endmodule

// ==== verification/uart_irq_fifo_control_bench.sv ====
// Self-checking bench for the interrupt and FIFO control block.
// Assumes a Wishbone slave answering one cycle after taking a request.
`timescale 1ns/1ps
module uart_irq_fifo_control_bench;
   localparam logic [6:0] RXS [4] = '{7'h01, 7'h04, 7'h08, 7'h0E};
   localparam logic [6:0] RXE [4] = '{7'h0F, 7'h1F, 7'h3F, 7'h6F};
   localparam logic [6:0] TXE [4] = '{7'h10, 7'h20, 7'h40, 7'h70};
   logic        clk_i, sys_rst_i, ce, cyc, stb, we, ack, err, enh, irq, fifo_en, rx_fl, tx_fl;
   logic [9:0]  adr;
   logic [3:0]  sel, dly;
   logic [31:0] wdat, rdat, r;
   logic [7:0]  src, ie, sv, f;
   logic [1:0]  done, k;
   logic [6:0]  rx_trig, tx_trig;
   int          bad_count, cmp_count, cyc_count, i, n, dv;

   uic_irq_fifo_ctl uic_irq_fifo_ctl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .enhanced_i(enh),
      .src_rx_err_i(src[0]), .src_rx_data_i(src[1]), .src_rx_tout_i(src[2]),
      .src_tx_empty_i(src[3]), .src_modem_i(src[4]), .src_xoff_i(src[5]),
      .src_rts_chg_i(src[6]), .src_cts_chg_i(src[7]), .rx_flush_done_i(done[0]),
      .tx_flush_done_i(done[1]), .irq_o(irq), .fifo_en_o(fifo_en), .rx_flush_o(rx_fl),
      .tx_flush_o(tx_fl), .rx_trig_o(rx_trig), .tx_trig_o(tx_trig));

   uic_fifo_model uic_fifo_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .delay_i(dly),
      .req_i({tx_fl, rx_fl}), .done_o(done));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic stop_test();
      if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Entered just after a rising edge; holds the request until ack or err, for at most 16 cycles
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] rv, output logic [1:0] resp);
      int c;
      c = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         c++;
      end while (ack !== 1'b1 && err !== 1'b1 && c < 16);
      rv = rdat;
      resp = {err, ack};
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'hF, r, k);
      chk({30'h0, k}, 32'h1);
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      wb(1'b0, a, 8'h00, 4'hF, r, k);
      chk({30'h0, k}, 32'h1);
      chk(r, e);
   endtask

   // Highest-priority enabled source; receive timeout follows enable bit 0
   function automatic logic [7:0] exp_id(input logic [7:0] e, input logic [7:0] s);
      if (s[0] & e[2]) return 8'hC6;
      if (s[1] & e[0]) return 8'hC4;
      if (s[2] & e[0]) return 8'hCC;
      if (s[3] & e[1]) return 8'hC2;
      if (s[4] & e[3]) return 8'hC0;
      if (s[5] & e[4]) return 8'hD0;
      if ((s[6] & e[5]) | (s[7] & e[6])) return 8'hE0;
      return 8'hC1;
   endfunction

   // ----------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc_count++;
      if (cyc_count == 30000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      {sys_rst_i, cyc, stb, we, enh, adr, sel, wdat, src, dly} = '0;
      sys_rst_i = 1'b1;
      ce = 1'b1;
      void'($urandom(32'h98BD));
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      rd(uic_pkg::ADR_INT_IDENT, 32'hC1);
      rd(uic_pkg::ADR_INT_ENABLE, 32'h0);
      chk({17'h0, rx_trig, tx_trig, fifo_en}, {17'h0, 7'h01, 7'h10, 1'b0});
      wb(1'b1, 10'h3FC, 8'hFF, 4'hF, r, k);
      chk({30'h0, k}, 32'h2);
      wb(1'b1, uic_pkg::ADR_INT_ENABLE, 8'hFF, 4'h0, r, k);
      chk({30'h0, k}, 32'h1);
      rd(uic_pkg::ADR_INT_ENABLE, 32'h0);
      // Corner cases first: everything enabled, sources from level i down
      for (i = 0; i < 200; i++) begin
         ie = (i < 8) ? 8'hFF : 8'($urandom);
         sv = (i < 8) ? 8'hFF << i : 8'($urandom);
         wr(uic_pkg::ADR_INT_ENABLE, ie);
         src <= sv;
         repeat (2) @(posedge clk_i);
         rd(uic_pkg::ADR_INT_ENABLE, {24'h0, ie});
         rd(uic_pkg::ADR_INT_IDENT, {24'h0, exp_id(ie, sv)});
         chk({31'h0, irq}, {31'h0, exp_id(ie, sv) != 8'hC1});
      end
      // Clock enable low must freeze the interrupt output
      ie = 8'h01;
      sv = 8'h02;
      wr(uic_pkg::ADR_INT_ENABLE, ie);
      src <= 8'h00;
      repeat (2) @(posedge clk_i);
      ce <= 1'b0;
      src <= sv;
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      ce <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h1);
      rd(uic_pkg::ADR_INT_IDENT, 32'hC4);
      for (i = 0; i < 32; i++) begin
         f = 8'($urandom);
         f[7:4] = i[3:0];
         f[2:1] = 2'b00;
         enh <= i[4];
         wr(uic_pkg::ADR_INT_IDENT, f);
         repeat (2) @(posedge clk_i);
         chk({15'h0, rx_trig, tx_trig, fifo_en, rx_fl, tx_fl}, {15'h0, i[4] ? RXE[f[7:6]] : RXS[f[7:6]],
             i[4] ? TXE[f[5:4]] : 7'h10, f[0], 2'b00});
         rd(uic_pkg::ADR_INT_IDENT, {24'h0, exp_id(ie, sv)});
         rd(uic_pkg::ADR_TRIG_LEVEL, {18'h0, i[4] ? TXE[f[5:4]] : 7'h10,
            i[4] ? RXE[f[7:6]] : RXS[f[7:6]]});
         rd(uic_pkg::ADR_SRC_STATUS, {24'h0, 2'b00, i[4], f[0], 3'h0,
            exp_id(ie, sv) != 8'hC1});
      end
      // Prompt then slow FIFO: strobes must start, wait for done, then clear
      for (i = 0; i < 2; i++) begin
         dv = (i == 1) ? 10 : 0;
         dly <= 4'(dv);
         wr(uic_pkg::ADR_INT_IDENT, 8'h07);
         chk({30'h0, rx_fl, tx_fl}, 32'h3);
         n = 0;
         while ((rx_fl === 1'b1 || tx_fl === 1'b1) && n < 40) begin
            @(posedge clk_i);
            n++;
         end
         chk({30'h0, rx_fl, tx_fl}, 32'h0);
         chk(n, dv + 1);
      end
      // Reset in mid-run must restore the registers and the trigger, FIFO enable, interrupt and receive flush outputs
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      chk({17'h0, rx_trig, tx_trig, fifo_en}, {17'h0, 7'h01, 7'h10, 1'b0});
      chk({30'h0, irq, rx_fl}, 32'h0);
      rd(uic_pkg::ADR_INT_IDENT, 32'hC1);
      rd(uic_pkg::ADR_INT_ENABLE, 32'h0);
      stop_test();
   end
endmodule
